//--- rtl/gp_event_regs.svh
`ifndef GP_EVENT_REGS_SVH
`define GP_EVENT_REGS_SVH
// Byte addresses of the registers on the AXI4-Lite slave.
`define GEV_CONTROL_ADDR 12'h0450
`define GEV_STATUS_ADDR 12'h0454
`define GEV_GPIO_ALT_ADDR 12'h0458
// Field positions in the control, status and GPIO alternate function registers.
`define GEV_POLARITY_BIT 0
`define GEV_PORT2_BIT 2
`define GEV_PORT4_BIT 4
`define GEV_PORT6_BIT 6
`define GEV_GPIO7_BIT 7
// Writable bits of the control register; the rest read as zero.
`define GEV_CONTROL_MASK 32'h0000_0055
`define GEV_RESET_VALUE 32'h0000_0000
// AXI response codes.
`define GEV_RESP_OKAY 2'h0
`define GEV_RESP_SLVERR 2'h2
`endif

//--- rtl/gp_event_pkg.sv
package gp_event_pkg;
  // Number of ports that may route events to the shared pin.
  localparam int unsigned NUM_EVT_PORTS = 3;
  typedef logic [NUM_EVT_PORTS-1:0] port_vec_t;
endpackage

//--- rtl/general_purpose_event_status.sv
`timescale 1ns/1ps
`include "gp_event_regs.svh"
// Summary of operation
// RL1 - Port 2 status flag, bit 2, set while port 2 drives the event pin.
// RL2 - Port 4 status flag, bit 4, set while port 4 drives the event pin.
// RL3 - Port 6 status flag, bit 6, set while port 6 drives the event pin.
// RL4 - A port's status flag stays clear whenever its event enable is off.
// RL5 - Event pin driven only when GPIO 7 is set to its alternate function.
// RL6 - Polarity invert 0 gives an active low pin, 1 active high.
// RL7 - Enabled ports lose in-band notifications; events go to the pin instead.
// RL8 - A flag clears once its port stops asserting the event pin.
module general_purpose_event_status
  import gp_event_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Event requests from ports 2, 4 and 6, bit 0 is port 2.
  input wire logic [NUM_EVT_PORTS-1:0] port_event_req,
  // In-band notification permission per port, bit 0 is port 2.
  output logic [NUM_EVT_PORTS-1:0] inband_notify_en,
  // GPIO 7 pin as output value and output enable.
  output logic event_output_pin,
  output logic event_output_pin_oe
);

  localparam int PORT_BIT [NUM_EVT_PORTS] = '{`GEV_PORT2_BIT,
                                              `GEV_PORT4_BIT,
                                              `GEV_PORT6_BIT};

  logic [31:0] ctrl_q, ctrl_d;
  logic alt_q, alt_d;
  port_vec_t flag_q, flag_d;
  port_vec_t enable;
  port_vec_t inband_d;
  logic pin_d, pin_oe_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status_word;
  logic do_write;
  logic awready_d, wready_d, arready_d;

  // Pick the enable bits out of the control word.
  for (genvar i = 0; i < NUM_EVT_PORTS; i++) begin : g_port
    assign enable[i] = ctrl_q[PORT_BIT[i]];
  end
  // Status word: each flag at its port's bit, reserved bits read as zero.
  always_comb begin
    status_word = '0;
    for (int i = 0; i < NUM_EVT_PORTS; i++) begin
      status_word[PORT_BIT[i]] = flag_q[i];
    end
  end

  // Event path: flags mirror the port's live contribution to the pin.
  always_comb begin
    for (int i = 0; i < NUM_EVT_PORTS; i++) begin
      // Set while asserting, clear on stop, held clear if disabled.
      flag_d[i] = enable[i] & port_event_req[i]; // see RL1 see RL2 see RL3
    end // see RL4 see RL8
    // Enabled ports route events to the pin, not in-band.
    inband_d = ~enable; // see RL7
    // Pin is only driven in alternate mode; polarity bit selects level.
    pin_oe_d = alt_q; // see RL5
    pin_d = ((|flag_d) & alt_q) ^ ~ctrl_q[`GEV_POLARITY_BIT]; // see RL6
    if (!alt_q) begin
      pin_d = ~ctrl_q[`GEV_POLARITY_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= '0;
      inband_notify_en <= '1;
      event_output_pin <= 1'b1;
      event_output_pin_oe <= 1'b0;
    end else begin
      flag_q <= flag_d;
      inband_notify_en <= inband_d;
      event_output_pin <= pin_d;
      event_output_pin_oe <= pin_oe_d;
    end
  end

  // Write channel: address and data are caught in either order.
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    alt_d = alt_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `GEV_RESP_OKAY;
      case ({awaddr_q[11:2], 2'b00})
        `GEV_CONTROL_ADDR: begin
          if (wstrb_q[0]) begin
            ctrl_d = wdata_q & `GEV_CONTROL_MASK;
          end
        end
        `GEV_GPIO_ALT_ADDR: begin
          if (wstrb_q[0]) begin
            alt_d = wdata_q[`GEV_GPIO7_BIT];
          end
        end
        // Status is read only; writes are dropped but acknowledged.
        `GEV_STATUS_ADDR: begin
        end
        default: begin
          bresp_d = `GEV_RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Ready only while the holding slot is empty and no response waits.
    // It drops for a cycle after each high, trading rate for simplicity.
    awready_d = !aw_held_d && !bvalid_d && !s_axi_awready;
    wready_d = !w_held_d && !bvalid_d && !s_axi_wready;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `GEV_RESP_OKAY;
      ctrl_q <= `GEV_RESET_VALUE;
      alt_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      ctrl_q <= ctrl_d;
      alt_q <= alt_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read channel: one read at a time, answered the cycle after address.
  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = `GEV_RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        `GEV_CONTROL_ADDR: rdata_d = ctrl_q;
        `GEV_STATUS_ADDR: rdata_d = status_word & `GEV_CONTROL_MASK;
        `GEV_GPIO_ALT_ADDR: rdata_d = {24'h00_0000, alt_q, 7'h00};
        default: begin
          rdata_d = `GEV_RESET_VALUE;
          rresp_d = `GEV_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // A new address is taken only when no read data waits.
    arready_d = !rvalid_d && !s_axi_arready;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= `GEV_RESP_OKAY;
      rdata_q <= `GEV_RESET_VALUE;
      s_axi_arready <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      s_axi_arready <= arready_d;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Checks on the event path.
  property p_flag_follows;
    @(posedge aclk) disable iff (!aresetn)
      ##1 flag_q == ($past(enable) & $past(port_event_req));
  endproperty
  a_flag_follows: assert property (p_flag_follows) // see RL1
    else $error("status flag does not follow enabled port request");
  property p_flag_off;
    @(posedge aclk) disable iff (!aresetn)
      !enable[0] |-> ##1 !flag_q[0];
  endproperty
  a_flag_off: assert property (p_flag_off) // see RL4
    else $error("flag set for disabled port");
  property p_flag_drop;
    @(posedge aclk) disable iff (!aresetn)
      flag_q[1] && !port_event_req[1] |=> !flag_q[1];
  endproperty
  a_flag_drop: assert property (p_flag_drop) // see RL8
    else $error("flag held after request ended");
  property p_port6;
    @(posedge aclk) disable iff (!aresetn)
      enable[2] && port_event_req[2] && $stable(enable) |=> flag_q[2];
  endproperty
  a_port6: assert property (p_port6) // see RL3
    else $error("port 6 flag missing");
  property p_oe;
    @(posedge aclk) disable iff (!aresetn)
      ##1 event_output_pin_oe == $past(alt_q);
  endproperty
  a_oe: assert property (p_oe) // see RL5
    else $error("pin enable not tied to alternate mode");
  property p_polarity;
    @(posedge aclk) disable iff (!aresetn)
      alt_q |=> event_output_pin ==
        ((|flag_q) ^ ~$past(ctrl_q[`GEV_POLARITY_BIT]));
  endproperty
  a_polarity: assert property (p_polarity) // see RL6
    else $error("pin level wrong for polarity");
  property p_inband;
    @(posedge aclk) disable iff (!aresetn)
      ##1 inband_notify_en == ~$past(enable);
  endproperty
  a_inband: assert property (p_inband) // see RL7
    else $error("in-band notification not suppressed");
  property p_port4;
    @(posedge aclk) disable iff (!aresetn)
      flag_q[1] |-> $past(port_event_req[1]);
  endproperty
  a_port4: assert property (p_port4) // see RL2
    else $error("port 4 flag without request");

endmodule

//--- testbench/event_pin_monitor.sv
`timescale 1ns/1ps
// Board logic watching the shared event pin, which has a pull-up.
module event_pin_monitor (
  // Pin value and enable as driven by the switch.
  input wire logic pin,
  input wire logic oe,
  // Active level the board expects: 0 low, 1 high.
  input wire logic pol,
  // High while the board sees an event.
  output logic asserted
);
  logic pin_lvl;
  // An undriven pin floats to the pull-up, never to the last value.
  assign pin_lvl = oe ? pin : 1'b1;
  // The board compares the wire against the chosen active level.
  assign asserted = (pin_lvl === pol);
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`include "gp_event_regs.svh"
module tb_top;
  logic aclk = 1'b0;
  logic aresetn;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, v, d;
  logic [31:0] s = 32'h0000_8030;
  logic [31:0] cfg = 32'h0000_0000;
  logic [3:0] ws;
  logic awv, awr, wv, wr, bv, brd, arv, arr, rv, rrd, pin, oe, seen, any;
  logic [1:0] br, rr, r;
  gp_event_pkg::port_vec_t req, nfy;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  // A 5 ns clock.
  always #2.5 aclk = ~aclk;
  general_purpose_event_status DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rrd), .port_event_req(req),
    .inband_notify_en(nfy), .event_output_pin(pin),
    .event_output_pin_oe(oe));
  event_pin_monitor board (.pin(pin), .oe(oe), .pol(cfg[0]),
    .asserted(seen));
  // Step through an LFSR so every run draws the same values.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Status flags: requests in bits 10:8 gated by the port enables.
  function automatic logic [31:0] flags(input logic [31:0] c);
    flags = 32'h0000_0000;
    flags[2] = c[8] & c[2];
    flags[4] = c[9] & c[4];
    flags[6] = c[10] & c[6];
  endfunction
  task automatic conclude;
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Every wait passes through here, so a hang ends the run.
  task automatic step;
    @(posedge aclk);
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      conclude;
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] x);
    checks++;
    if (x !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, x);
    end
  endtask
  // Address and data go out together; each drops once it is taken.
  task automatic wrt(input logic [11:0] a, input logic [31:0] x);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awa <= a;
    wd <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && dd)) begin
      step;
      if (awr) ad = 1'b1;
      if (wr) dd = 1'b1;
      if (ad) awv <= 1'b0;
      if (dd) wv <= 1'b0;
    end
    while (!bv) step;
    r = br;
  endtask
  task automatic rdt(input logic [11:0] a);
    ara <= a;
    arv <= 1'b1;
    do step; while (!arr);
    arv <= 1'b0;
    while (!rv) step;
    v = rd;
    r = rr;
  endtask
  // Response ready lines stay high, which the bus allows.
  initial begin
    aresetn <= 1'b0;
    {awa, ara, wd, awv, wv, arv, req} <= '0;
    {brd, rrd, ws} <= {2'b11, 4'hf};
    repeat (2) step;
    aresetn <= 1'b1;
    step;
    rdt(`GEV_STATUS_ADDR);
    chk("status reset", 32'h0000_0000, v);
    rdt(`GEV_CONTROL_ADDR);
    chk("control reset", `GEV_RESET_VALUE, v);
    rdt(12'h045C);
    chk("unmapped rresp", `GEV_RESP_SLVERR, r);
    chk("unmapped rdata", 32'h0000_0000, v);
    for (int i = 0; i < 40; i++) begin
      s = lfsr(s);
      d = (i == 0) ? 32'h0000_07d5 : (i == 1) ? 32'h0000_0700 : s;
      req <= d[10:8];
      wrt(`GEV_CONTROL_ADDR, d);
      wrt(`GEV_GPIO_ALT_ADDR, d);
      wrt(`GEV_STATUS_ADDR, ~d);
      chk("status write bresp", `GEV_RESP_OKAY, r);
      cfg = d;
      any = |flags(d);
      step;
      step;
      chk("pin enable", d[7], oe);
      if (d[7]) chk("pin level", {any ^ ~d[0]}, pin);
      else chk("idle pin", {~d[0]}, pin);
      chk("board event", d[7] ? any : d[0], seen);
      chk("in-band", {~{d[6], d[4], d[2]}}, nfy);
      rdt(`GEV_CONTROL_ADDR);
      chk("control", d & `GEV_CONTROL_MASK, v);
      rdt(`GEV_STATUS_ADDR);
      chk("status", flags(d), v);
    end
    // Writes with byte 0 masked off or to a hole change nothing.
    ws <= 4'he;
    wrt(`GEV_CONTROL_ADDR, ~d);
    ws <= 4'hf;
    rdt(`GEV_CONTROL_ADDR);
    chk("strobed control", d & `GEV_CONTROL_MASK, v);
    wrt(12'h045C, d);
    chk("unmapped bresp", `GEV_RESP_SLVERR, r);
    // A reset in mid-run returns the pin and the in-band lines to idle.
    aresetn <= 1'b0;
    step;
    step;
    chk("reset pin enable", 1'b0, oe);
    chk("reset pin", 1'b1, pin);
    chk("reset in-band", 3'b111, nfy);
    aresetn <= 1'b1;
    step;
    rdt(`GEV_STATUS_ADDR);
    chk("status after reset", 32'h0000_0000, v);
    conclude;
  end
endmodule
